//--- rstseq_pkg.sv
package rstseq_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] BREAK_STATUS_ADDR       = 16'hFE00;
  localparam logic [15:0] RESET_CAUSE_STATUS_ADDR = 16'hFE01;
  localparam logic [15:0] BREAK_FLAG_CONTROL_ADDR = 16'hFE03;

  // Reset cause bit positions.
  localparam int CAUSE_POR_BIT  = 7;
  localparam int CAUSE_PIN_BIT  = 6;
  localparam int CAUSE_WDOG_BIT = 5;
  localparam int CAUSE_BAD_OPCODE_FLAG_BIT = 4;
  localparam int CAUSE_BAD_ADDRESS_FLAG_BIT = 3;
  localparam int CAUSE_LVI_BIT  = 1;

  // Break register bit positions.
  localparam int BREAK_WAIT_BIT  = 1;
  localparam int BREAK_CLEAR_BIT = 7;

  // Reset values.
  localparam logic [7:0] CAUSE_RESET = 8'h80;
  localparam logic [7:0] BREAK_RESET = 8'h00;

  // Reset vectors.
  localparam logic [15:0] VECTOR_USER    = 16'hFFFE;
  localparam logic [15:0] VECTOR_MONITOR = 16'hFEFE;

  // ****************************************
  // Timing, in reference clock cycles except the _NS values in ns
  // ****************************************
  localparam int BUS_DIVIDE     = 4;
  localparam int LONG_CYC       = 4096;
  localparam int SHORT_CYC      = 32;
  localparam int PIN_DRIVE_CYC  = 32;
  localparam int INTERNAL_RESET_EXTRA_CYC = 32;
  localparam int RELEASE_CYC    = 3;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int MIN_RST_LOW_NS = 100;
  localparam int MIN_RST_LOW_CYC =
    (MIN_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Sequencer states, Gray along the usual path
  // ****************************************
  typedef enum logic [3:0] {
    ST_LONG  = 4'b0000,
    ST_DRIVE = 4'b0001,
    ST_HOLD  = 4'b0011,
    ST_RUN   = 4'b0010,
    ST_WAIT  = 4'b0110,
    ST_STOP  = 4'b0111,
    ST_SREC  = 4'b0101,
    ST_EXT   = 4'b0100
  } seq_state_t;

endpackage : rstseq_pkg

//--- system_reset_clock_sequencer.sv
// Behaviour
// - Bus runs at reference or PLL divided by four.
// - Power-on/undervoltage: clocks off, pin low 4096 cycles.
// - Stop wake: counter times 4096 or 32 cycles.
// - Wait mode stops CPU clocks, peripherals keep theirs.
// - Resets pick FFFE vector, FEFE in monitor mode.
// - Internal reset returns break registers to defaults.
// - Internal resets clear counter, external reset does not.
// - Each reset source sets its own cause flag.
// - Pin low halts; flag needs minimum low time.
// - Internal sources drive pin 32, then hold 32.
// - Recovery 4163 after power/undervoltage, else 67.
// - Watchdog request accepted asynchronously, then synchronised.
// - Power-on: release CPU 67 cycles after 4096 count.
// - Power-on sets its flag, clears all others.
// - Watchdog overflow resets unless watchdog disabled.
// - Illegal opcode resets; stop illegal when not enabled.
// - Only unmapped opcode fetch causes address reset.
// - Undervoltage resets unless disabled; holds pin until recovery.
// - 12-bit counter on falling reference edge feeds watchdog.
// - Stop clears counter; wake samples short-recovery bit.
// - Counter runs freely after reset completes.
// - Power-on enables clock generator output.
// - Stop disables clock outputs, holds counter cleared.
`timescale 1ns/1ns
module system_reset_clock_sequencer
  import rstseq_pkg::*;
#(
  parameter int CNT_W = 12
) (
  // Clock and reset; clk is the oscillator reference clock.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Reset sources, asynchronous to clk.
  input  wire logic        power_on_pulse,
  input  wire logic        undervoltage_detector,
  input  wire logic        watchdog_timeout,
  // External reset pin, open drain.
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  // CPU status, same clock domain.
  input  wire logic        cpu_illegal_opcode,
  input  wire logic        cpu_stop_exec,
  input  wire logic        cpu_wait_exec,
  input  wire logic        cpu_opcode_fetch,
  input  wire logic        addr_unmapped,
  input  wire logic        wake_event,
  input  wire logic        break_in_wait,
  // Configuration bits.
  input  wire logic        watchdog_disable,
  input  wire logic        undervoltage_power_disable,
  input  wire logic        undervoltage_reset_disable,
  input  wire logic        short_stop_recovery,
  input  wire logic        stop_enable,
  input  wire logic        monitor_mode,
  // Clock generator side.
  input  wire logic        pll_select,
  input  wire logic        pll_out_pulse,
  // Register port.
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  // System outputs.
  output logic             internal_reset,
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             clock_gen_output_en,
  output logic             osc_ref_en,
  output logic             bus_tick,
  output logic             watchdog_clock,
  output logic [15:0]      reset_vector
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       por_s;
  logic       lvi_s;
  logic       wdog_s;
  logic       pin_s;

  // The watchdog request is asynchronous to the bus, so it is synchronised here.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 4'h8;
      sync2_q <= 4'h8;
    end else begin
      sync1_q <= {reset_pin_in, watchdog_timeout, undervoltage_detector, power_on_pulse};
      sync2_q <= sync1_q;
    end
  end

  assign por_s  = sync2_q[0];
  assign lvi_s  = sync2_q[1];
  assign wdog_s = sync2_q[2];
  assign pin_s  = sync2_q[3];

  // ****************************************
  // State and event decode
  // ****************************************
  seq_state_t       state_q;
  seq_state_t       state_d;
  logic [6:0]       stage_q;
  logic [CNT_W-1:0] cnt_q;
  logic             int_src_q;
  logic             short_stop_recovery_q;
  logic             pin_drive_q;
  logic [6:0]       low_cnt_q;
  logic             wrap_q;
  logic [1:0]       drive_echo_q;
  logic             run;
  logic             lvi_ev;
  logic             wdog_ev;
  logic             bad_opcode_flag_ev;
  logic             bad_address_flag_ev;
  logic             long_ev;
  logic             int_ev;
  logic             ext_ev;
  logic             cnt_clr;

  assign run     = (state_q == ST_RUN);
  assign lvi_ev  = lvi_s && !undervoltage_power_disable && !undervoltage_reset_disable;
  assign wdog_ev = wdog_s && !watchdog_disable;
  assign bad_opcode_flag_ev = run && (cpu_illegal_opcode || (cpu_stop_exec && !stop_enable));
  assign bad_address_flag_ev = run && cpu_opcode_fetch && addr_unmapped;
  assign long_ev = por_s || lvi_ev;
  assign int_ev  = long_ev || wdog_ev || bad_opcode_flag_ev || bad_address_flag_ev;
  // Our own drive comes back through the synchroniser two cycles late, so a delayed copy masks that echo.
  assign ext_ev  = !pin_s && !pin_drive_q && !drive_echo_q[1];

  // Counter clear requests; an external reset leaves the counter alone.
  assign cnt_clr = int_ev || (state_q == ST_STOP) || (state_q == ST_LONG && long_ev);

  // Next state; resets outrank every other transition.
  always_comb begin
    state_d = state_q;
    if (long_ev) begin
      state_d = ST_LONG;
    end else if (int_ev) begin
      state_d = ST_DRIVE;
    end else if (ext_ev && state_q != ST_LONG) begin
      state_d = ST_EXT;
    end else begin
      case (state_q)
        // Leaving on the wrap gives the full 4096 counted cycles in long reset.
        ST_LONG:  if (wrap_q) state_d = ST_DRIVE;
        ST_DRIVE: if (stage_q == 7'(PIN_DRIVE_CYC - 1)) state_d = ST_HOLD;
        ST_HOLD:  if (stage_q == 7'(PIN_DRIVE_CYC + INTERNAL_RESET_EXTRA_CYC + RELEASE_CYC - 1)) state_d = ST_RUN;
        ST_RUN: begin
          if (cpu_stop_exec && stop_enable) state_d = ST_STOP;
          else if (cpu_wait_exec) state_d = ST_WAIT;
        end
        ST_WAIT:  if (wake_event) state_d = ST_RUN;
        ST_STOP:  if (wake_event) state_d = ST_SREC;
        // Short recovery waits for the count of 32, the long one for the counter's wrap.
        ST_SREC:  if (short_stop_recovery_q ? (cnt_q == CNT_W'(SHORT_CYC)) : wrap_q) state_d = ST_RUN;
        ST_EXT:   if (pin_s) state_d = ST_DRIVE;
        default:  state_d = ST_LONG;
      endcase
    end
  end

  // State register; rst_n stands for the first power-up.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_LONG;
    end else begin
      state_q <= state_d;
    end
  end

  // Stage counter for the pin drive and hold phases.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= 7'h00;
    end else if (state_d == ST_DRIVE && state_q != ST_DRIVE) begin
      stage_q <= 7'h00;
    end else if (state_q == ST_DRIVE || state_q == ST_HOLD) begin
      stage_q <= stage_q + 7'h01;
    end
  end

  // An external reset drives the pin only if ST_EXT lasts a single cycle; internal sources do.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_src_q <= 1'b1;
    end else if (int_ev) begin
      int_src_q <= 1'b1;
    end else if (state_q == ST_EXT) begin
      int_src_q <= 1'b0;
    end
  end

  // Short recovery is sampled once on wake so a later change cannot skew it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      short_stop_recovery_q <= 1'b0;
    end else if (state_q == ST_STOP && wake_event) begin
      short_stop_recovery_q <= short_stop_recovery;
    end
  end

  // Length of an outside low on the pin, saturating at the minimum.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt_q <= 7'h00;
    end else if (state_q != ST_EXT) begin
      low_cnt_q <= 7'h00;
    end else if (low_cnt_q != 7'(MIN_RST_LOW_CYC)) begin
      low_cnt_q <= low_cnt_q + 7'h01;
    end
  end

  // ****************************************
  // System counter on the falling edge
  // ****************************************

  // Free running except on internal reset requests and in stop; wraps to zero.
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      wrap_q <= 1'b0;
    end else if (cnt_clr) begin
      cnt_q  <= '0;
      wrap_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_q + CNT_W'(1);
      wrap_q <= (cnt_q == '1);
    end
  end

  // ****************************************
  // Clock control and outputs
  // ****************************************
  logic [1:0] div_q;
  logic       step;

  assign step = pll_select ? pll_out_pulse : 1'b1;

  // Bus divider; it freezes while the peripheral clocks are off.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q    <= 2'h0;
      bus_tick <= 1'b0;
    end else begin
      bus_tick <= 1'b0;
      if (periph_clk_en && step) begin
        div_q    <= div_q + 2'h1;
        bus_tick <= (div_q == 2'(BUS_DIVIDE - 1));
      end
    end
  end

  // Registered system outputs follow the next state, watchdog_clock the counter wrap.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      internal_reset      <= 1'b1;
      cpu_clk_en          <= 1'b0;
      periph_clk_en       <= 1'b0;
      clock_gen_output_en <= 1'b1;
      osc_ref_en          <= 1'b1;
      pin_drive_q         <= 1'b1;
      drive_echo_q        <= 2'h3;
      watchdog_clock      <= 1'b0;
    end else begin
      internal_reset      <= (state_d == ST_LONG) || (state_d == ST_DRIVE) ||
                             (state_d == ST_HOLD) || (state_d == ST_EXT);
      cpu_clk_en          <= (state_d == ST_RUN);
      periph_clk_en       <= (state_d == ST_RUN) || (state_d == ST_WAIT);
      clock_gen_output_en <= (state_d != ST_STOP);
      osc_ref_en          <= (state_d != ST_STOP);
      pin_drive_q         <= (state_d == ST_LONG) ||
                             (state_d == ST_DRIVE && (int_ev || int_src_q));
      watchdog_clock      <= wrap_q;
      drive_echo_q        <= {drive_echo_q[0], pin_drive_q};  // Tracks the pin through the synchroniser.
    end
  end

  assign reset_pin_out = 1'b0;
  assign reset_pin_oe  = pin_drive_q;

  // Vector chosen on every reset entry.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_vector <= VECTOR_USER;
    end else if (int_ev || ext_ev) begin
      reset_vector <= monitor_mode ? VECTOR_MONITOR : VECTOR_USER;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] cause_q;
  logic [7:0] brk_stat_q;
  logic [7:0] brk_ctl_q;

  // Cause flags ignore writes; power-on clears the rest.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_q <= CAUSE_RESET;
    end else if (por_s) begin
      cause_q <= CAUSE_RESET;
    end else begin
      if (lvi_ev)  cause_q[CAUSE_LVI_BIT]  <= 1'b1;
      if (wdog_ev) cause_q[CAUSE_WDOG_BIT] <= 1'b1;
      if (bad_opcode_flag_ev) cause_q[CAUSE_BAD_OPCODE_FLAG_BIT] <= 1'b1;
      if (bad_address_flag_ev) cause_q[CAUSE_BAD_ADDRESS_FLAG_BIT] <= 1'b1;
      if (low_cnt_q == 7'(MIN_RST_LOW_CYC)) cause_q[CAUSE_PIN_BIT] <= 1'b1;
    end
  end

  // Break registers return to defaults on internal reset; set beats clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brk_stat_q <= BREAK_RESET;
      brk_ctl_q  <= BREAK_RESET;
    end else if (internal_reset) begin
      brk_stat_q <= BREAK_RESET;
      brk_ctl_q  <= BREAK_RESET;
    end else begin
      if (break_in_wait && state_q == ST_WAIT) begin
        brk_stat_q[BREAK_WAIT_BIT] <= 1'b1;
      end else if (reg_wr && reg_addr == BREAK_STATUS_ADDR && !reg_wdata[BREAK_WAIT_BIT]) begin
        brk_stat_q[BREAK_WAIT_BIT] <= 1'b0;
      end
      if (reg_wr && reg_addr == BREAK_FLAG_CONTROL_ADDR) begin
        brk_ctl_q[BREAK_CLEAR_BIT] <= reg_wdata[BREAK_CLEAR_BIT];
      end
    end
  end

  // Read data is registered; other addresses read zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        BREAK_STATUS_ADDR:       reg_rdata <= brk_stat_q;
        RESET_CAUSE_STATUS_ADDR: reg_rdata <= cause_q;
        BREAK_FLAG_CONTROL_ADDR: reg_rdata <= brk_ctl_q;
        default:                 reg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_long_pin_low: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_LONG) |-> reset_pin_oe && !cpu_clk_en && !periph_clk_en)
    else $error("pin not driven or clocks running in long reset");
  a_drive_to_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_DRIVE && stage_q == 7'd31 && !int_ev && !ext_ev) |=> (state_q == ST_HOLD))
    else $error("pin drive phase not 32 cycles");
  a_hold_release: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_HOLD && stage_q == 7'd66 && !int_ev && !ext_ev) |=> !internal_reset && cpu_clk_en)
    else $error("reset not released after 67 cycles");
  a_por_cause: assert property (@(posedge clk) disable iff (!rst_n)
    por_s |=> (cause_q == 8'h80))
    else $error("power-on cause not exclusive");
  a_bad_address_flag_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (bad_address_flag_ev && !por_s) |=> cause_q[CAUSE_BAD_ADDRESS_FLAG_BIT] && internal_reset)
    else $error("bad address reset missing");
  a_wait_clocks: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_WAIT) |-> !cpu_clk_en && periph_clk_en)
    else $error("wait clocks wrong");
  a_stop_cleared: assert property (@(posedge clk) disable iff (!rst_n)
    (state_q == ST_STOP) ##1 (state_q == ST_STOP) |-> (cnt_q == '0) && !clock_gen_output_en)
    else $error("counter running in stop");
  a_cause_ro: assert property (@(posedge clk) disable iff (!rst_n)
    (!int_ev && low_cnt_q != 7'(MIN_RST_LOW_CYC)) |=> $stable(cause_q))
    else $error("cause register changed without reset");
  a_vector_mon: assert property (@(posedge clk) disable iff (!rst_n)
    (int_ev && monitor_mode) |=> (reset_vector == VECTOR_MONITOR))
    else $error("monitor vector not selected");
  a_wdog_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    watchdog_clock |=> !watchdog_clock)
    else $error("watchdog clock pulse longer than one cycle");

endmodule : system_reset_clock_sequencer

//--- reset_pin_partner.sv
`timescale 1ns/1ns
// ****************************************
// External reset pin and PLL strobe
// ****************************************
module reset_pin_partner (
  // Clock and device side.
  input  wire logic clk,
  input  wire logic dev_oe,
  // Resolved pin and clock strobe.
  output logic      pin_level,
  output logic      pll_strobe
);
  logic ext_low  = 1'b0;
  logic toggle_q = 1'b0;

  // The pin is open drain with a pull-up, so any party pulling low wins.
  assign pin_level = (dev_oe || ext_low) ? 1'b0 : 1'b1;

  // A strobe every second cycle makes the PLL path run at half rate.
  always @(posedge clk) begin
    toggle_q <= ~toggle_q;
  end
  assign pll_strobe = toggle_q;

  // Holds the pin low for n cycles; it changes only just after an edge.
  task automatic pull(input int n);
    @(posedge clk);
    #1;
    ext_low = 1'b1;
    repeat (n) @(posedge clk);
    #1;
    ext_low = 1'b0;
  endtask : pull
endmodule : reset_pin_partner

//--- system_reset_clock_sequencer_tb.sv
`timescale 1ns/1ns
module system_reset_clock_sequencer_tb;
  import rstseq_pkg::*;
  typedef struct packed {
    logic       bad_opcode_flag;
    logic       stp;
    logic       ftch;
    logic       unm;
    logic       mon;
    logic [7:0] flag;
  } row_t;
  logic clk, rst_n, power_on_pulse, undervoltage_detector, watchdog_timeout;
  logic cpu_illegal_opcode, cpu_stop_exec, cpu_wait_exec, cpu_opcode_fetch;
  logic addr_unmapped, wake_event, break_in_wait, watchdog_disable;
  logic undervoltage_power_disable, undervoltage_reset_disable;
  logic short_stop_recovery, stop_enable, monitor_mode, pll_select;
  logic reg_rd, reg_wr, reset_pin_in, reset_pin_out, reset_pin_oe;
  logic pll_out_pulse, internal_reset, cpu_clk_en, periph_clk_en;
  logic clock_gen_output_en, osc_ref_en, bus_tick, watchdog_clock;
  logic [15:0] reg_addr, reset_vector;
  logic [7:0]  reg_wdata, reg_rdata, acc, d;
  int          failures, n_compared, oe_n, ir_n, n, ex;
  row_t        rows [4] = '{'{1, 0, 0, 0, 1, 8'h10}, '{0, 1, 0, 0, 0, 8'h10},
                            '{0, 0, 1, 1, 0, 8'h08}, '{0, 0, 0, 1, 0, 8'h00}};

  system_reset_clock_sequencer u_system_reset_clock_sequencer (
    .clk, .rst_n, .power_on_pulse, .undervoltage_detector, .watchdog_timeout,
    .reset_pin_in, .reset_pin_out, .reset_pin_oe, .cpu_illegal_opcode,
    .cpu_stop_exec, .cpu_wait_exec, .cpu_opcode_fetch, .addr_unmapped,
    .wake_event, .break_in_wait, .watchdog_disable, .undervoltage_power_disable,
    .undervoltage_reset_disable, .short_stop_recovery, .stop_enable,
    .monitor_mode, .pll_select, .pll_out_pulse, .reg_addr, .reg_rd, .reg_wr,
    .reg_wdata, .reg_rdata, .internal_reset, .cpu_clk_en, .periph_clk_en,
    .clock_gen_output_en, .osc_ref_en, .bus_tick, .watchdog_clock,
    .reset_vector);
  reset_pin_partner u_reset_pin_partner (.clk, .dev_oe(reset_pin_oe),
    .pin_level(reset_pin_in), .pll_strobe(pll_out_pulse));

  // ****************************************
  // Clock, watchdog and shared tasks
  // ****************************************
  // The reference clock runs at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The whole run needs about 21000 cycles, so this cuts only a real hang.
  initial begin
    #1_000_000;
    failures++;
    conclude();
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse

  // Each strobe is dropped a cycle before the next access may raise it again.
  task automatic rd(input logic [15:0] a, output logic [7:0] q);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    q = reg_rdata;
    reg_rd = 1'b0;
    cyc(1);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask : wr

  task automatic cause_is(input logic [7:0] e);
    rd(RESET_CAUSE_STATUS_ADDR, d);
    chk(16'(d), 16'(e));
  endtask : cause_is

  // Counts the cycles of pin drive and internal reset from the reset's rise.
  task automatic measure();
    oe_n = 0;
    ir_n = 0;
    for (int i = 0; i < 8 && internal_reset !== 1'b1; i++) cyc(1);
    while (internal_reset === 1'b1 && ir_n < 9000) begin
      ir_n++;
      if (reset_pin_oe === 1'b1) oe_n++;
      cyc(1);
    end
  endtask : measure

  task automatic conclude();
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {power_on_pulse, undervoltage_detector, watchdog_timeout} = 3'b000;
    {cpu_illegal_opcode, cpu_stop_exec, cpu_wait_exec} = 3'b000;
    {cpu_opcode_fetch, addr_unmapped, wake_event, break_in_wait} = 4'h0;
    {watchdog_disable, undervoltage_power_disable} = 2'b00;
    {undervoltage_reset_disable, short_stop_recovery, stop_enable} = 3'b000;
    {monitor_mode, pll_select, reg_rd, reg_wr} = 4'h0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    failures = 0;
    n_compared = 0;
    rst_n = 1'b0;
    cyc(3);
    chk(16'(internal_reset), 16'h0001);
    chk(16'(reset_pin_oe), 16'h0001);
    chk(16'(cpu_clk_en), 16'h0000);
    chk(reset_vector, VECTOR_USER);
    chk(16'(reset_pin_out), 16'h0000);
    rst_n = 1'b1;
    measure();
    chk(16'(oe_n >= LONG_CYC), 16'h0001);
    chk(16'(ir_n >= 4163 && ir_n <= 4172), 16'h0001);
    chk(16'(cpu_clk_en), 16'h0001);
    chk(16'(clock_gen_output_en), 16'h0001);
    cause_is(CAUSE_RESET);
    wr(RESET_CAUSE_STATUS_ADDR, 8'hFF);
    cause_is(CAUSE_RESET);
    wr(BREAK_FLAG_CONTROL_ADDR, 8'h80);
    rd(BREAK_FLAG_CONTROL_ADDR, d);
    chk(16'(d), 16'h0080);
    rd(16'hFE02, d);
    chk(16'(d), 16'h0000);
    acc = CAUSE_RESET;
    // Ordinary CPU events, one row each, with the flags they should add.
    foreach (rows[r]) begin
      monitor_mode = rows[r].mon;
      {cpu_illegal_opcode, cpu_stop_exec} = {rows[r].bad_opcode_flag, rows[r].stp};
      {cpu_opcode_fetch, addr_unmapped} = {rows[r].ftch, rows[r].unm};
      cyc(1);
      {cpu_illegal_opcode, cpu_stop_exec, cpu_opcode_fetch, addr_unmapped} = 4'h0;
      if (rows[r].flag != 8'h00) begin
        measure();
        chk(16'(oe_n), 16'(PIN_DRIVE_CYC));
        chk(16'(ir_n), 16'(PIN_DRIVE_CYC + INTERNAL_RESET_EXTRA_CYC + RELEASE_CYC));
        chk(reset_vector, rows[r].mon ? VECTOR_MONITOR : VECTOR_USER);
        acc = acc | rows[r].flag;
      end else begin
        cyc(6);
        chk(16'(internal_reset), 16'h0000);
      end
      cause_is(acc);
    end
    rd(BREAK_FLAG_CONTROL_ADDR, d);
    chk(16'(d), 16'h0000);
    // Watchdog request is disabled first, then taken.
    for (int k = 0; k < 2; k++) begin
      watchdog_disable = (k == 0);
      pulse(watchdog_timeout);
      measure();
      chk(16'(ir_n), (k == 0) ? 16'h0000 : 16'h0043);
      acc = acc | ((k == 0) ? 8'h00 : 8'h20);
      cause_is(acc);
    end
    // A pin pulse shorter than the minimum low time must not set the flag.
    u_reset_pin_partner.pull(5);
    for (int i = 0; i < 200 && internal_reset !== 1'b0; i++) cyc(1);
    cause_is(acc);
    u_reset_pin_partner.pull(MIN_RST_LOW_CYC + 10);
    for (int i = 0; i < 200 && internal_reset !== 1'b0; i++) cyc(1);
    acc = acc | 8'h40;
    cause_is(acc);
    // Either disable bit blocks the undervoltage reset.
    for (int k = 0; k < 3; k++) begin
      undervoltage_power_disable = (k == 0);
      undervoltage_reset_disable = (k == 1);
      pulse(undervoltage_detector);
      measure();
      chk(16'(ir_n == 0), (k < 2) ? 16'h0001 : 16'h0000);
      acc = acc | ((k < 2) ? 8'h00 : 8'h02);
      cause_is(acc);
    end
    chk(16'(ir_n >= 4163 && ir_n <= 4172), 16'h0001);
    pulse(power_on_pulse);
    measure();
    chk(16'(ir_n >= 4163 && ir_n <= 4172), 16'h0001);
    cause_is(CAUSE_RESET);
    // Wait stops only the CPU clock.
    pulse(cpu_wait_exec);
    cyc(1);
    chk(16'(cpu_clk_en), 16'h0000);
    chk(16'(periph_clk_en), 16'h0001);
    pulse(break_in_wait);
    pulse(wake_event);
    cyc(2);
    chk(16'(cpu_clk_en), 16'h0001);
    rd(BREAK_STATUS_ADDR, d);
    chk(16'(d), 16'h0002);
    wr(BREAK_STATUS_ADDR, 8'h00);
    rd(BREAK_STATUS_ADDR, d);
    chk(16'(d), 16'h0000);
    // Bus ticks in 40 cycles: every 4 steps, steps every cycle or every other.
    for (int k = 0; k < 2; k++) begin
      pll_select = k[0];
      cyc(4);
      n = 0;
      repeat (40) begin
        cyc(1);
        if (bus_tick === 1'b1) n++;
      end
      chk(16'(n), 16'(40 / (BUS_DIVIDE * (k + 1))));
    end
    // Stop with short and then long recovery.
    stop_enable = 1'b1;
    for (int k = 0; k < 2; k++) begin
      short_stop_recovery = (k == 0);
      pulse(cpu_stop_exec);
      cyc(1);
      chk(16'(clock_gen_output_en), 16'h0000);
      chk(16'(osc_ref_en), 16'h0000);
      chk(16'(cpu_clk_en), 16'h0000);
      pulse(wake_event);
      n = 0;
      while (cpu_clk_en !== 1'b1 && n < 5000) begin
        n++;
        cyc(1);
      end
      ex = (k == 0) ? SHORT_CYC : LONG_CYC;
      chk(16'(n >= ex && n <= ex + 8), 16'h0001);
    end
    // Spacing of watchdog clock pulses shows the 12-bit wrap.
    for (int i = 0; i < 5000 && watchdog_clock !== 1'b1; i++) cyc(1);
    cyc(1);
    n = 1;
    while (watchdog_clock !== 1'b1 && n < 5000) begin
      n++;
      cyc(1);
    end
    chk(16'(n), 16'(LONG_CYC));
    conclude();
  end
endmodule : system_reset_clock_sequencer_tb
